// [core/acmp_defs.vh]
`ifndef ACMP_DEFS_VH
`define ACMP_DEFS_VH

// Register byte offsets on the APB bus
`define OFS_CTRL1     8'h00
`define OFS_CTRL2     8'h04
`define OFS_SHARED    8'h08
`define OFS_FLAGS     8'h0C
`define OFS_IRQEN     8'h10

// Per-comparator control register fields
`define B_ON          7
`define B_OUT         6
`define B_OE          5
`define B_POL         4
`define B_SP          3
`define B_REF         2
`define F_CH          1:0
`define CTRL_RESET    8'h08
`define CTRL_WMASK    8'hBF

// Shared control register fields, channel i uses base minus i
`define SH_MOUT       7
`define SH_RSEL       5
`define SH_HYS        3
`define SH_SYNC       1
`define SHARED_RESET  8'h00
`define SHARED_WMASK  8'h3F

// Interrupt enable register fields
`define IE_GLOBAL     7
`define IE_PERIPH     6
`define IRQEN_RESET   8'h00
`define IRQEN_WMASK   8'hC3
`define FLAGS_RESET   2'h0

// Four-phase system clock
`define PH_W          2
`define PH_ONE        2'h0
`define PH_THREE      2'h2
`define PH_STEP       2'h1

`endif

// [core/comp_channel.v]
`timescale 1ns/10ps
`include "acmp_defs.vh"

// One comparator: input muxes, compare, polarity, mismatch latches, sync
module comp_channel #(
  parameter AW = 10
) (
  input  wire          clk,          // System clock
  input  wire          rst,          // Synchronous reset, high
  input  wire          ce,           // Clock enable
  input  wire [AW-1:0] inv_pin_0,    // Inverting candidate 0
  input  wire [AW-1:0] inv_pin_1,    // Inverting candidate 1
  input  wire [AW-1:0] inv_pin_2,    // Inverting candidate 2
  input  wire [AW-1:0] inv_pin_3,    // Inverting candidate 3
  input  wire [AW-1:0] noninv_pin,   // External non-inverting pin
  input  wire [AW-1:0] int_ref,      // Internal reference level
  input  wire          comp_enable,  // Comparator on
  input  wire          output_invert,// Polarity
  input  wire          ref_source_select,        // 1 internal ref, 0 pin
  input  wire [1:0]    inverting_channel_select, // Inverting channel
  input  wire          clock_phase_one,          // First-phase strobe
  input  wire          reload,       // Control access at third phase
  input  wire          sync_enable,  // Timer sync enable
  input  wire          timer_clk,    // Timer source clock, sampled
  output wire          async_result, // Unlatched polarity-adjusted result
  output reg           comp_result,  // Second latch, per cycle
  output wire          mismatch_rise,// Pulse on new mismatch
  output wire          sync_result   // Result for timer gating
);

  reg [AW-1:0] vin_minus;
  reg          first_latch;
  reg          mis_d;
  reg          tclk_d;
  reg          sync_q;
  wire [AW-1:0] vin_plus;
  wire          raw;
  wire          mismatch;

  // Inverting input channel mux
  always @* begin
    case (inverting_channel_select)
      2'h0:    vin_minus = inv_pin_0;
      2'h1:    vin_minus = inv_pin_1;
      2'h2:    vin_minus = inv_pin_2;
      default: vin_minus = inv_pin_3;
    endcase
  end

  assign vin_plus = ref_source_select ? int_ref : noninv_pin;
  assign raw = (vin_plus > vin_minus);
  // Off comparator feeds a 0 into polarity and mismatch paths
  assign async_result = (comp_enable & raw) ^ output_invert;

  // Mismatch latch pair; reload captures pre-write value
  always @(posedge clk) begin
    if (rst) begin
      first_latch <= 1'b0;
      comp_result <= 1'b0;
      mis_d       <= 1'b0;
    end else if (ce) begin
      if (reload)
        first_latch <= async_result;
      if (clock_phase_one)
        comp_result <= async_result;
      mis_d <= mismatch;
    end
  end

  assign mismatch = first_latch ^ comp_result;
  // Edge, not level, so flag clears stick
  assign mismatch_rise = mismatch & ~mis_d;

  // Latch on timer clock falling edge, avoids gating race
  always @(posedge clk) begin
    if (rst) begin
      tclk_d <= 1'b0;
      sync_q <= 1'b0;
    end else if (ce) begin
      tclk_d <= timer_clk;
      if (tclk_d & ~timer_clk)
        sync_q <= async_result;
    end
  end

  assign sync_result = sync_enable ? sync_q : async_result;

endmodule // comp_channel

// [core/comparator_control.v]
// Decided for this implementation: the placing of the registers and register access over APB.
`timescale 1ns/10ps
`include "acmp_defs.vh"

module comparator_control #(
  parameter AW = 10
) (
  input  wire            clk,                    // System clock
  input  wire            rst,                    // Synchronous reset, high
  input  wire            ce,                     // Clock enable, freezes all
  input  wire            psel,                   // APB select
  input  wire            penable,                // APB enable
  input  wire            pwrite,                 // APB write
  input  wire [7:0]      paddr,                  // APB byte address
  input  wire [31:0]     pwdata,                 // APB write data
  output reg  [31:0]     prdata,                 // APB read data
  output wire            pready,                 // APB ready
  output wire            pslverr,                // APB error
  input  wire [AW-1:0]   inverting_pin_0,        // Shared inverting pin 0
  input  wire [AW-1:0]   inverting_pin_1,        // Shared inverting pin 1
  input  wire [AW-1:0]   inverting_pin_2,        // Shared inverting pin 2
  input  wire [AW-1:0]   inverting_pin_3,        // Shared inverting pin 3
  input  wire [2*AW-1:0] noninverting_pin,       // Per-channel + pin
  input  wire [2*AW-1:0] internal_reference_out, // Per-channel reference
  input  wire [1:0]      port_direction_bit,     // 1 input, 0 output
  input  wire            sleep,                  // Sleep mode
  input  wire            timer1_clk,             // Timer source clock
  output wire [1:0]      comp_power_on,          // Analog bias on
  output wire [1:0]      speed_power_select,     // 1 normal, 0 low power
  output wire [1:0]      ref_choice,             // Internal ref source pick
  output wire [1:0]      hysteresis_enable,      // Hysteresis on
  output wire [1:0]      comp_pin_out,           // Pin data
  output wire [1:0]      comp_pin_oe,            // Pin override active
  output wire [1:0]      sync_result,            // Timer gate result
  output wire            comp_irq                // Interrupt request
);

  reg  [`PH_W-1:0] phase;
  reg  [7:0]       shared_reg;
  reg  [7:0]       irq_en;
  reg  [1:0]       comp_change_flag;
  reg  [31:0]      rdata_mux;
  wire [15:0]      ctrl_bus;
  wire [1:0]       next_flag;
  wire             clock_phase_one;
  wire             clock_phase_three;
  wire             setup;
  wire             xfer;
  wire             wr;
  wire [1:0]       hit_ctrl;
  wire             hit_shared;
  wire             hit_flags;
  wire             hit_irqen;
  wire             mapped;
  wire [1:0]       async_result;
  wire [1:0]       comp_result;
  wire [1:0]       mismatch_rise;
  wire [1:0]       comp_enable;
  wire [1:0]       pin_output_enable;
  wire [1:0]       comp_change_irq_enable;

  // Four-phase counter; sleep forces first phase active
  always @(posedge clk) begin
    if (rst)
      phase <= `PH_ONE;
    else if (ce)
      phase <= phase + `PH_STEP;
  end

  assign clock_phase_one   = (phase == `PH_ONE) | sleep;
  assign clock_phase_three = (phase == `PH_THREE);

  // APB handshake; access completes at third phase
  assign setup   = psel & ~penable;
  assign pready  = psel & penable & clock_phase_three & ce;
  assign xfer    = psel & penable & pready;
  assign wr      = xfer & pwrite;
  assign pslverr = xfer & ~mapped;

  // Address decode
  assign hit_ctrl[0] = (paddr == `OFS_CTRL1);
  assign hit_ctrl[1] = (paddr == `OFS_CTRL2);
  assign hit_shared  = (paddr == `OFS_SHARED);
  assign hit_flags   = (paddr == `OFS_FLAGS);
  assign hit_irqen   = (paddr == `OFS_IRQEN);
  assign mapped      = |hit_ctrl | hit_shared | hit_flags | hit_irqen;

  // Shared register; result mirrors are read-only
  always @(posedge clk) begin
    if (rst)
      shared_reg <= `SHARED_RESET;
    else if (ce & wr & hit_shared)
      shared_reg <= pwdata[7:0] & `SHARED_WMASK;
  end

  // Interrupt enables: per-channel low bits, peripheral, global
  always @(posedge clk) begin
    if (rst)
      irq_en <= `IRQEN_RESET;
    else if (ce & wr & hit_irqen)
      irq_en <= pwdata[7:0] & `IRQEN_WMASK;
  end

  genvar i;
  generate
    for (i = 0; i < 2; i = i + 1) begin : g_ch
      reg [7:0] ctrl_q;
      reg       next_bit;

      // Control register; result bit is read-only
      always @(posedge clk) begin
        if (rst)
          ctrl_q <= `CTRL_RESET;
        else if (ce & wr & hit_ctrl[i])
          ctrl_q <= pwdata[7:0] & `CTRL_WMASK;
      end

      // One driver per channel slice of the control bus
      assign ctrl_bus[i*8 +: 8]        = ctrl_q;
      assign comp_enable[i]            = ctrl_q[`B_ON];
      assign pin_output_enable[i]      = ctrl_q[`B_OE];
      assign comp_change_irq_enable[i] = irq_en[i];

      // Analog-side controls
      assign comp_power_on[i]      = comp_enable[i];
      assign speed_power_select[i] = ctrl_q[`B_SP];
      assign ref_choice[i]         = shared_reg[`SH_RSEL - i];
      assign hysteresis_enable[i]  = shared_reg[`SH_HYS - i];

      // Pin override ignores enable; data needs enable too
      assign comp_pin_oe[i]  = pin_output_enable[i] & ~port_direction_bit[i];
      assign comp_pin_out[i] = comp_pin_oe[i] & comp_enable[i]
                               & async_result[i];

      // Both channels identical; reload on any access to the channel's own control register
      comp_channel #(
        .AW (AW)
      ) i_comp_channel (
        .clk           (clk),
        .rst           (rst),
        .ce            (ce),
        .inv_pin_0     (inverting_pin_0),
        .inv_pin_1     (inverting_pin_1),
        .inv_pin_2     (inverting_pin_2),
        .inv_pin_3     (inverting_pin_3),
        .noninv_pin    (noninverting_pin[i*AW +: AW]),
        .int_ref       (internal_reference_out[i*AW +: AW]),
        .comp_enable   (comp_enable[i]),
        .output_invert            (ctrl_q[`B_POL]),
        .ref_source_select        (ctrl_q[`B_REF]),
        .inverting_channel_select (ctrl_q[`F_CH]),
        .clock_phase_one          (clock_phase_one),
        .reload        (xfer & hit_ctrl[i]),
        .sync_enable   (shared_reg[`SH_SYNC - i]),
        .timer_clk     (timer1_clk),
        .async_result  (async_result[i]),
        .comp_result   (comp_result[i]),
        .mismatch_rise (mismatch_rise[i]),
        .sync_result   (sync_result[i])
      );

      // Flag: set beats software clear; output enable not involved
      always @* begin
        next_bit = comp_change_flag[i];
        if (wr & hit_flags)
          next_bit = pwdata[i];
        if (mismatch_rise[i])
          next_bit = 1'b1;
      end

      assign next_flag[i] = next_bit;
    end
  endgenerate

  // Flag storage
  always @(posedge clk) begin
    if (rst)
      comp_change_flag <= `FLAGS_RESET;
    else if (ce)
      comp_change_flag <= next_flag;
  end

  // Request needs channel, peripheral and global enables
  assign comp_irq = |(comp_change_flag & comp_change_irq_enable)
                    & irq_en[`IE_PERIPH] & irq_en[`IE_GLOBAL];

  // Read mux; mirror read leaves mismatch latches alone
  always @* begin
    rdata_mux = 32'h00000000;
    case (paddr)
      `OFS_CTRL1: begin
        rdata_mux[7:0]    = ctrl_bus[7:0];
        rdata_mux[`B_OUT] = comp_result[0];
      end
      `OFS_CTRL2: begin
        rdata_mux[7:0]    = ctrl_bus[15:8];
        rdata_mux[`B_OUT] = comp_result[1];
      end
      `OFS_SHARED: begin
        rdata_mux[7:0]        = shared_reg;
        rdata_mux[`SH_MOUT]   = comp_result[0];
        rdata_mux[`SH_MOUT-1] = comp_result[1];
      end
      `OFS_FLAGS:  rdata_mux[1:0] = comp_change_flag;
      `OFS_IRQEN:  rdata_mux[7:0] = irq_en;
      default:     rdata_mux = 32'h00000000;
    endcase
  end

  // Read data registered in every cycle of a transfer except the one with pready high
  always @(posedge clk) begin
    if (rst)
      prdata <= 32'h00000000;
    else if (ce & (setup | (psel & ~pready)))
      prdata <= rdata_mux;
  end

endmodule // comparator_control

// [tb/acmp_checker.sv]
`timescale 1ns/10ps
`include "acmp_defs.vh"

module acmp_checker (
  input wire        clk,                // System clock
  input wire        rst,                // Synchronous reset
  input wire        psel,               // APB select
  input wire        penable,            // APB enable
  input wire        pwrite,             // APB write
  input wire [7:0]  paddr,              // APB address
  input wire [31:0] pwdata,             // APB write data
  input wire        pready,             // APB ready
  input wire        pslverr,            // APB error
  input wire [1:0]  port_direction_bit, // Pin direction
  input wire [1:0]  comp_power_on,      // Enable bits
  input wire [1:0]  speed_power_select, // Speed bits
  input wire [1:0]  comp_pin_out,       // Pin data
  input wire [1:0]  comp_pin_oe,        // Pin override
  input wire        comp_irq            // Interrupt request
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);

  // Completed transfers, write ones kept apart for history checks
  wire acc    = psel && penable && pready;
  wire wr_acc = acc && pwrite;

  ready_bound_a: assert property ($rose(penable) |-> ##[0:4] pready)
    else $error("ready did not follow access phase");
  ready_once_a: assert property (pready |=> !pready)
    else $error("ready held longer than one cycle");
  err_map_a: assert property (pready && paddr[1:0] == 2'h0 |-> pslverr == (paddr > 8'h10))
    else $error("error response does not match address map");
  enable_write_a: assert property (
    wr_acc && paddr == `OFS_CTRL1 |=> comp_power_on[0] == $past(pwdata[`B_ON]))
    else $error("enable bit did not take written value");
  enable_hold_a: assert property (!$stable(comp_power_on) |-> $past(wr_acc))
    else $error("enable changed without a write");
  reset_state_a: assert property (
    $past(rst) |-> speed_power_select == 2'h3 && comp_power_on == 2'h0 && !comp_irq)
    else $error("state after reset is wrong");
  pin_gate_a: assert property (
    (comp_pin_out & ~(comp_pin_oe & comp_power_on)) == 2'h0)
    else $error("pin driven without enable and override");
  oe_dir_a: assert property (
    (comp_pin_oe & port_direction_bit) == 2'h0)
    else $error("override active on an input pin");

  cover property (wr_acc && paddr == `OFS_CTRL1);
  cover property ($rose(comp_irq));
  cover property (comp_pin_out != 2'h0);
  cover property (pslverr);
endmodule // acmp_checker

bind comparator_control acmp_checker i_acmp_checker (
  .clk(clk), .rst(rst), .psel(psel), .penable(penable), .pwrite(pwrite),
  .paddr(paddr), .pwdata(pwdata), .pready(pready), .pslverr(pslverr),
  .port_direction_bit(port_direction_bit), .comp_power_on(comp_power_on),
  .speed_power_select(speed_power_select), .comp_pin_out(comp_pin_out),
  .comp_pin_oe(comp_pin_oe), .comp_irq(comp_irq)
);

// [tb/analog_src.sv]
`timescale 1ns/10ps

module analog_src (
  input  wire        clk,       // System clock
  input  wire        plus_high, // Channel 1 + pin high or low
  output wire [9:0]  inv_0,     // Inverting pin 0
  output wire [9:0]  inv_1,     // Inverting pin 1
  output wire [9:0]  inv_2,     // Inverting pin 2
  output wire [9:0]  inv_3,     // Inverting pin 3
  output reg  [19:0] plus_pins, // + pins, channel 2 always high
  output wire [19:0] ref_out    // Internal references, both low
);
  // Steps of 200; only channel code 3 lies above the high + level of 600
  assign inv_0   = 10'h064;
  assign inv_1   = 10'h12C;
  assign inv_2   = 10'h1F4;
  assign inv_3   = 10'h2BC;
  assign ref_out = {10'h032, 10'h032};

  // Level lags the request a cycle, like a source that must slew
  initial plus_pins = {10'h258, 10'h258};
  always @(posedge clk) begin
    plus_pins <= {10'h258, plus_high ? 10'h258 : 10'h032};
  end
endmodule // analog_src

// [tb/comparator_control_tb.sv]
`timescale 1ns/10ps
`include "acmp_defs.vh"

module analog_comparator_control_tb;
  reg         clk = 1'b0;
  reg         rst = 1'b1;
  reg         psel = 1'b0;
  reg         penable = 1'b0;
  reg         pwrite = 1'b0;
  reg  [7:0]  paddr = 8'h00;
  reg  [31:0] pwdata = 32'h0;
  reg  [1:0]  dir = 2'h3;
  reg         plus_high = 1'b1;
  reg         slp = 1'b0;
  reg         tclk = 1'b0;
  reg  [7:0]  ex;
  wire [31:0] prdata;
  wire        pready, pslverr, irq;
  wire [9:0]  inv0, inv1, inv2, inv3;
  wire [19:0] plus_pins, ref_out;
  wire [1:0]  power_on, speed, pin_out, pin_oe, rsel, hys, sync;
  integer     errors = 0;
  integer     checks_done = 0;
  integer     k;
  reg         b, err;
  reg  [31:0] rd;

  always #5 clk = ~clk;

  analog_src i_analog_src (.clk(clk), .plus_high(plus_high), .inv_0(inv0), .inv_1(inv1),
    .inv_2(inv2), .inv_3(inv3), .plus_pins(plus_pins), .ref_out(ref_out));

  comparator_control i_comparator_control (.clk(clk), .rst(rst), .ce(1'b1), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .inverting_pin_0(inv0), .inverting_pin_1(inv1),
    .inverting_pin_2(inv2), .inverting_pin_3(inv3), .noninverting_pin(plus_pins),
    .internal_reference_out(ref_out), .port_direction_bit(dir), .sleep(slp),
    .timer1_clk(tclk), .comp_power_on(power_on), .speed_power_select(speed),
    .ref_choice(rsel), .hysteresis_enable(hys), .comp_pin_out(pin_out), .comp_pin_oe(pin_oe),
    .sync_result(sync), .comp_irq(irq));

  task check(input [31:0] seen, input [31:0] exp);
    begin
      checks_done = checks_done + 1;
      if (seen !== exp) begin
        errors = errors + 1;
        $display("Error at %0t: seen %h expected %h", $time, seen, exp);
      end
    end
  endtask

  task report_and_stop;
    begin
      $display("Comparisons %0d, mismatches %0d", checks_done, errors);
      if (errors == 0 && checks_done > 0)
        $display("Test passed");
      else
        $display("Test failed");
      $finish;
    end
  endtask

  // One APB transfer; request stands until pready is seen at a rising edge
  task xfer(input w, input [7:0] a, input [31:0] d);
    integer n;
    begin
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge clk);
      penable <= 1'b1;
      @(posedge clk);
      for (n = 0; n < 20 && pready !== 1'b1; n = n + 1)
        @(posedge clk);
      if (pready !== 1'b1) begin
        errors = errors + 1;
        report_and_stop;
      end
      // Taken at the completing edge, then released; one idle edge follows
      rd = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      @(posedge clk);
    end
  endtask

  task wr(input [7:0] a, input [7:0] d);
    xfer(1'b1, a, {24'h0, d});
  endtask

  task rdc(input [7:0] a, input [7:0] e);
    begin
      xfer(1'b0, a, 32'h0);
      check(rd, {24'h0, e});
    end
  endtask

  task idle(input integer n);
    repeat (n) @(posedge clk);
  endtask

  initial begin
    repeat (20) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    // Reset values, then an unmapped place
    rdc(`OFS_CTRL1, `CTRL_RESET);
    rdc(`OFS_CTRL2, `CTRL_RESET);
    rdc(`OFS_SHARED, `SHARED_RESET);
    rdc(`OFS_FLAGS, 8'h00);
    rdc(`OFS_IRQEN, `IRQEN_RESET);
    rdc(8'h20, 8'h00);
    check(err, 1'b1);
    check(power_on, 2'h0);
    check(speed, 2'h3);
    // Every channel code under both references and polarities
    for (k = 0; k < 16; k = k + 1) begin
      b = ((k[2] ? 50 : 600) > 100 + 200 * (k % 4)) ^ k[3];
      ex = {1'b1, b, 1'b0, k[3], 1'b0, k[2], k[1:0]};
      wr(`OFS_CTRL1, {3'h4, k[3], 1'b0, k[2], k[1:0]});
      idle(4);
      rdc(`OFS_CTRL1, ex);
    end
    // Second channel on its own control
    wr(`OFS_CTRL2, 8'h81);
    idle(4);
    rdc(`OFS_CTRL2, 8'hC1);
    check(speed, 2'h0);
    // Pin path needs override, enable and an output pin
    dir <= 2'h2;
    wr(`OFS_CTRL1, 8'hA0);
    idle(4);
    check({pin_oe, pin_out}, 4'h5);
    wr(`OFS_CTRL1, 8'h20);
    check({pin_oe, pin_out}, 4'h4);
    dir <= 2'h3;
    idle(2);
    check(pin_oe, 2'h0);
    // Change flag: edge set, no reload, reload, forced set, masking
    wr(`OFS_IRQEN, 8'hC1);
    wr(`OFS_CTRL1, 8'h80);
    idle(8);
    rdc(`OFS_CTRL1, 8'hC0);
    wr(`OFS_FLAGS, 8'h00);
    plus_high <= 1'b0;
    idle(8);
    rdc(`OFS_FLAGS, 8'h01);
    check(irq, 1'b1);
    wr(`OFS_FLAGS, 8'h00);
    idle(8);
    rdc(`OFS_FLAGS, 8'h00);
    plus_high <= 1'b1;
    idle(8);
    rdc(`OFS_FLAGS, 8'h00);
    plus_high <= 1'b0;
    idle(8);
    rdc(`OFS_FLAGS, 8'h01);
    rdc(`OFS_CTRL1, 8'h80);
    wr(`OFS_FLAGS, 8'h00);
    plus_high <= 1'b1;
    idle(8);
    rdc(`OFS_FLAGS, 8'h01);
    // Write reloads the first latch, so a return flags; output enable on
    wr(`OFS_CTRL1, 8'hA0);
    wr(`OFS_FLAGS, 8'h00);
    idle(8);
    rdc(`OFS_FLAGS, 8'h00);
    plus_high <= 1'b0;
    idle(8);
    rdc(`OFS_FLAGS, 8'h01);
    wr(`OFS_FLAGS, 8'h00);
    wr(`OFS_IRQEN, 8'h41);
    wr(`OFS_FLAGS, 8'h01);
    rdc(`OFS_FLAGS, 8'h01);
    check(irq, 1'b0);
    wr(`OFS_IRQEN, 8'hC1);
    idle(2);
    check(irq, 1'b1);
    // Sleep opens the second latch every edge: flag three edges on
    rdc(`OFS_CTRL1, 8'hA0);
    wr(`OFS_FLAGS, 8'h00);
    slp <= 1'b1;
    plus_high <= 1'b1;
    idle(3);
    @(negedge clk);
    check(irq, 1'b1);
    @(posedge clk);
    slp <= 1'b0;
    // Shared register: reference pick, hysteresis, sync, result mirrors
    wr(`OFS_SHARED, 8'h2A);
    rdc(`OFS_SHARED, 8'hEA);
    check({rsel, hys}, 4'h5);
    check(sync, 2'h2);
    tclk <= 1'b1;
    idle(2);
    tclk <= 1'b0;
    idle(3);
    check(sync, 2'h3);
    plus_high <= 1'b0;
    idle(4);
    check(sync, 2'h3);
    report_and_stop;
  end
endmodule // analog_comparator_control_tb
